// ### shared/tcb_pkg.sv
package tcb_pkg;
  // =====================================================================
  // sizes and reset values
  localparam int          CNT_W    = 16;
  localparam int          PSC_W    = 10;
  localparam int          FINE_MAX = 3;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] PER_RST  = 16'hFFFF;

  // =====================================================================
  // clock select: 0 stopped, 1..7 prescaler taps, 8 event clock
  localparam logic [3:0]      CLK_OFF = 4'h0;
  localparam logic [3:0]      CLK_EV  = 4'h8;
  // log2 of the divide ratio for taps 1,2,4,8,64,256,1024
  localparam logic [7:0][3:0] PSC_TAP = {4'hA, 4'h8, 4'h6, 4'h3, 4'h2, 4'h1, 4'h0, 4'h0};

  typedef enum logic [1:0] {
    TCB_WG_NORMAL = 2'b00,
    TCB_WG_FRQ    = 2'b01,
    TCB_WG_SS     = 2'b10,
    TCB_WG_DS     = 2'b11
  } tcb_wgm_t;

  // =====================================================================
  // counter view shared with every channel
  typedef struct packed {
    logic             tick;
    logic             upd;
    logic             split;
    logic             fine_en;
    logic             cap_mode;
    tcb_wgm_t         wgm;
    logic [CNT_W-1:0] cnt;
  } tcb_ctl_t;

  typedef struct packed {
    logic [CNT_W-1:0]    cc;
    logic [CNT_W-1:0]    buf_v;
    logic                bv;
    logic                full;
    logic                ev;
    logic                hev;
    logic                err;
    logic                dma;
    logic                wave;
    logic [FINE_MAX-1:0] fine;
  } tcb_ch_st_t;

  typedef struct packed {
    logic [3:0]       sel;
    logic [PSC_W-1:0] psc;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] per;
    logic [CNT_W-1:0] pbuf;
    logic             pbv;
    logic             dsdn;
    logic             tick;
    logic             upd;
    logic             bot;
    logic             max;
    logic             ovf;
    logic             hovf;
    logic             err;
    logic             dma;
  } tcb_top_st_t;

  localparam tcb_top_st_t TOP_RST = '{per: PER_RST, bot: 1'b1, default: '0};
endpackage : tcb_pkg

// ### logic/tcb_chan.sv
`timescale 1ns/100ps
module tcb_chan #(
  parameter int FB = 2
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  ce,
  input  wire tcb_pkg::tcb_ctl_t     ctl,
  input  wire logic                  en,
  input  wire logic                  buf_wr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  cap,
  input  wire logic                  rd,
  input  wire logic                  ack,
  output tcb_pkg::tcb_ch_st_t        st
);
  tcb_pkg::tcb_ch_st_t q, d;
  logic [15:0] cmp;
  logic        hit;
  logic        hit_hi;

  // =====================================================================
  // next state
  always_comb begin
    d = q;
    d.ev = 1'b0;
    d.hev = 1'b0;
    d.err = 1'b0;
    // in fine mode the low bits place the edge inside the cycle
    cmp = q.cc >> (ctl.fine_en ? FB : 0);
    hit = ctl.tick && en && (ctl.split ? ctl.cnt[7:0] == q.cc[7:0] : ctl.cnt == cmp);
    hit_hi = ctl.tick && en && ctl.split && ctl.cnt[15:8] == q.cc[15:8];
    if (ctl.cap_mode) begin
      if (rd) begin
        d.full = 1'b0;
      end
      if (cap && en) begin
        if (!d.full && q.bv) begin
          // the older buffered sample goes first, the new one queues behind it
          d.cc = q.buf_v;
          d.full = 1'b1;
          d.ev = 1'b1;
          d.buf_v = ctl.cnt;
        end else if (!d.full) begin
          d.cc = ctl.cnt;
          d.full = 1'b1;
          d.ev = 1'b1;
        end else if (!q.bv) begin
          d.buf_v = ctl.cnt;
          d.bv = 1'b1;
        end else begin
          d.err = 1'b1;
        end
      end else if (!d.full && q.bv) begin
        d.cc = q.buf_v;
        d.full = 1'b1;
        d.bv = 1'b0;
        d.ev = 1'b1;
      end
    end else begin
      if (ctl.upd && q.bv) begin
        d.cc = q.buf_v;
        d.bv = 1'b0;
      end
      // a write in the update cycle keeps the flag set
      if (buf_wr) begin
        d.buf_v = wdata;
        d.bv = 1'b1;
      end
      d.ev = hit;
      d.hev = hit_hi;
      if (hit) begin
        d.fine = ctl.fine_en ? q.cc[2:0] & 3'((4'h1 << FB) - 4'h1) : 3'h0;
      end
      case (ctl.wgm)
        tcb_pkg::TCB_WG_SS: begin
          if (ctl.upd) d.wave = 1'b1;
          if (hit) d.wave = 1'b0;
        end
        tcb_pkg::TCB_WG_FRQ, tcb_pkg::TCB_WG_DS: begin
          if (hit) d.wave = ~q.wave;
        end
        default: d.wave = q.wave;
      endcase
    end
    if (ack) d.dma = 1'b0;
    if (d.ev) d.dma = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign st = q;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_bv_set;
    ce && buf_wr && !ctl.cap_mode |=> q.bv && q.buf_v == $past(wdata);
  endproperty
  a_bv_set: assert property (p_bv_set) else $error("buffer valid not set");

  property p_cap;
    ce && ctl.cap_mode && cap && en && !rd && !q.full && !q.bv |=> q.cc == $past(ctl.cnt) && q.ev;
  endproperty
  a_cap: assert property (p_cap) else $error("capture lost");

  c_cap: cover property (ce && ctl.cap_mode && cap && en && q.full && !q.bv);
endmodule : tcb_chan

// ### logic/tcb_timer.sv
`timescale 1ns/100ps
// What this block does
// - 16-bit counter, overflow event chains two units
// - four channels, or two in second variant
// - unit runs capture or compare, never both
// - split into two 8-bit counters, four-channel only
// - bottom flagged when count becomes zero
// - max flagged when count is all ones
// - top is period or channel A, by mode
// - update at bottom or top, by mode
// - clock from prescaler or event; event direction/capture/restart
// - per-channel event; overflow and error events
// - period buffered, taken on update
// - channels double buffered for compare and capture
// - dma requests on overflow and channel events
// - fine extension adds two or three bits
// - up wraps to zero, down reloads top; dual slope turns at both ends instead
// - buffer flag set on write, cleared on update
// - no clock selected after reset
// - count write wins over count, clear, reload
module tcb_timer #(
  parameter int NUM_CH    = 4,
  parameter int FINE_BITS = 2
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  ce,
  input  wire logic [3:0]            clk_sel,
  input  wire logic                  ev_clk,
  input  wire logic                  ev_dir_en,
  input  wire logic                  ev_dir_up,
  input  wire logic                  ev_restart,
  input  wire logic                  dir_dn,
  input  wire tcb_pkg::tcb_wgm_t     wgm,
  input  wire logic                  cap_mode,
  input  wire logic                  split_en,
  input  wire logic                  fine_en,
  input  wire logic                  cnt_wr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  per_buf_wr,
  input  wire logic [NUM_CH-1:0]     cc_en,
  input  wire logic [NUM_CH-1:0]     cc_buf_wr,
  input  wire logic [NUM_CH-1:0]     cap_ev,
  input  wire logic [NUM_CH-1:0]     cc_rd,
  input  wire logic                  dma_ack_ovf,
  input  wire logic [NUM_CH-1:0]     dma_ack_cc,
  output logic [15:0]                cnt_o,
  output logic [15:0]                per_o,
  output logic                       per_bv_o,
  output logic                       bottom_o,
  output logic                       max_o,
  output logic                       update_o,
  output logic                       ovf_ev,
  output logic                       hovf_ev,
  output logic                       err_ev,
  output logic                       dma_ovf_req,
  output tcb_pkg::tcb_ch_st_t [NUM_CH-1:0] ch_o
);
  // =====================================================================
  // elaboration checks
  if (NUM_CH != 2 && NUM_CH != 4) begin : g_bad_ch
    $error("NUM_CH must be 2 or 4");
  end
  if (FINE_BITS != 2 && FINE_BITS != 3) begin : g_bad_fine
    $error("FINE_BITS must be 2 or 3");
  end

  tcb_pkg::tcb_top_st_t q, d;
  tcb_pkg::tcb_ctl_t    ctl;
  logic [9:0]           mask;
  logic                 tick;
  logic                 up;
  logic                 split;
  logic [15:0]          top;
  logic [NUM_CH-1:0]    ch_err;

  // =====================================================================
  // counter
  always_comb begin
    d = q;
    d.ovf = 1'b0;
    d.hovf = 1'b0;
    d.upd = 1'b0;
    d.sel = clk_sel;
    d.psc = q.psc + 10'h001;
    mask = 10'((11'h001 << tcb_pkg::PSC_TAP[q.sel[2:0]]) - 11'h001);
    // stopped until a source is chosen; codes above 8 also stop it
    if (q.sel == tcb_pkg::CLK_EV) begin
      tick = ev_clk;
    end else begin
      tick = q.sel != tcb_pkg::CLK_OFF && q.sel < tcb_pkg::CLK_EV && (q.psc & mask) == mask;
    end
    d.tick = tick;
    split = split_en && NUM_CH == 4;
    top = wgm == tcb_pkg::TCB_WG_FRQ ? ch_o[0].cc : q.per;
    up = ev_dir_en ? ev_dir_up : !dir_dn;
    if (wgm == tcb_pkg::TCB_WG_DS) up = !q.dsdn;
    if (tick && split) begin
      if (q.cnt[7:0] == 8'h00) begin
        d.cnt[7:0] = q.per[7:0];
        d.ovf = 1'b1;
      end else begin
        d.cnt[7:0] = q.cnt[7:0] - 8'h01;
      end
      if (q.cnt[15:8] == 8'h00) begin
        d.cnt[15:8] = q.per[15:8];
        d.hovf = 1'b1;
      end else begin
        d.cnt[15:8] = q.cnt[15:8] - 8'h01;
      end
      d.upd = d.ovf;
    end else if (tick) begin
      if (up && q.cnt == top) begin
        if (wgm == tcb_pkg::TCB_WG_DS) begin
          d.dsdn = 1'b1;
          d.cnt = q.cnt - 16'h0001;
        end else begin
          d.cnt = tcb_pkg::CNT_RST;
          d.ovf = 1'b1;
          d.upd = 1'b1;
        end
      end else if (!up && q.cnt == 16'h0000) begin
        if (wgm == tcb_pkg::TCB_WG_DS) begin
          d.dsdn = 1'b0;
          d.cnt = 16'h0001;
        end else begin
          d.cnt = top;
        end
        d.ovf = 1'b1;
        d.upd = 1'b1;
      end else begin
        d.cnt = up ? q.cnt + 16'h0001 : q.cnt - 16'h0001;
      end
    end
    if (ev_restart) begin
      d.cnt = tcb_pkg::CNT_RST;
      d.dsdn = 1'b0;
    end
    if (cnt_wr) begin
      d.cnt = wdata;
    end
    if (d.upd && q.pbv) begin
      d.per = q.pbuf;
      d.pbv = 1'b0;
    end
    if (per_buf_wr) begin
      d.pbuf = wdata;
      d.pbv = 1'b1;
    end
    d.bot = d.cnt == 16'h0000;
    d.max = &d.cnt;
    d.err = |ch_err;
    if (dma_ack_ovf) d.dma = 1'b0;
    if (d.ovf) d.dma = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= tcb_pkg::TOP_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // =====================================================================
  // channels see the counter one cycle after it moves
  always_comb begin
    ctl = '0;
    ctl.tick = q.tick;
    ctl.upd = q.upd;
    ctl.split = split_en && NUM_CH == 4;
    ctl.fine_en = fine_en;
    ctl.cap_mode = cap_mode;
    ctl.wgm = wgm;
    ctl.cnt = q.cnt;
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    tcb_chan #(.FB(FINE_BITS)) u_ch (
      .clk    (clk),
      .rst_b  (rst_b),
      .ce     (ce),
      .ctl    (ctl),
      .en     (cc_en[i]),
      .buf_wr (cc_buf_wr[i]),
      .wdata  (wdata),
      .cap    (cap_ev[i]),
      .rd     (cc_rd[i]),
      .ack    (dma_ack_cc[i]),
      .st     (ch_o[i])
    );
    assign ch_err[i] = ch_o[i].err;
  end

  assign cnt_o       = q.cnt;
  assign per_o       = q.per;
  assign per_bv_o    = q.pbv;
  assign bottom_o    = q.bot;
  assign max_o       = q.max;
  assign update_o    = q.upd;
  assign ovf_ev      = q.ovf;
  assign hovf_ev     = q.hovf;
  assign err_ev      = q.err;
  assign dma_ovf_req = q.dma;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_wr_wins;
    ce && cnt_wr |=> q.cnt == $past(wdata);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("count write lost");

  property p_stopped;
    q.sel == tcb_pkg::CLK_OFF && ce && !cnt_wr && !ev_restart |=> q.cnt == $past(q.cnt);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counting with no clock");

  property p_wrap;
    ce && tick && !split && up && q.cnt == top && wgm != tcb_pkg::TCB_WG_DS
      && !cnt_wr && !ev_restart |=> q.cnt == 16'h0000 && q.ovf ##1 q.ovf == 1'b0 || !ce;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to zero at top");

  property p_bot;
    q.bot == (q.cnt == 16'h0000);
  endproperty
  a_bot: assert property (p_bot) else $error("bottom flag wrong");

  property p_max;
    q.max == (q.cnt == 16'hFFFF);
  endproperty
  a_max: assert property (p_max) else $error("max flag wrong");

  property p_per;
    ce && q.pbv && d.upd && !per_buf_wr |=> q.per == $past(q.pbuf) && !q.pbv;
  endproperty
  a_per: assert property (p_per) else $error("period not taken on update");

  property p_dma;
    q.ovf |-> q.dma;
  endproperty
  a_dma: assert property (p_dma) else $error("overflow without dma request");

  c_ovf: cover property (q.ovf);
  c_split: cover property (q.hovf);
  c_per: cover property (q.upd && $past(q.pbv));
endmodule : tcb_timer

// ### tb/tcb_evsys_model.sv
`timescale 1ns/100ps
// =====================================================================
// far side: event channel that clocks the counter, and the dma engine
module tcb_evsys_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ev_go,
  input  wire logic       ack_en,
  input  wire logic       dma_ovf_req,
  output logic            ev_clk,
  output logic            dma_ack_ovf,
  output logic [7:0]      ev_n
);
  logic [7:0] sr_q;

  // irregular pulse spacing, so a counter that only counts cycles shows up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_q <= 8'hA5;
      ev_clk <= 1'b0;
      dma_ack_ovf <= 1'b0;
      ev_n <= 8'h00;
    end else begin
      sr_q <= {sr_q[6:0], sr_q[7] ^ sr_q[5] ^ sr_q[4] ^ sr_q[3]};
      ev_clk <= ev_go & sr_q[0];
      ev_n <= ev_n + {7'h00, ev_go & sr_q[0]};
      // ack_en low models a slow dma engine that leaves the request pending
      dma_ack_ovf <= ack_en & dma_ovf_req & ~dma_ack_ovf;
    end
  end
endmodule : tcb_evsys_model

// ### tb/test_timer_counter_base_16bit.sv
`timescale 1ns/100ps
module test_timer_counter_base_16bit;
  // =====================================================================
  // signals
  logic                clk        = 1'b0;
  logic                rst_b      = 1'b0;
  logic                ce         = 1'b1;
  logic [3:0]          clk_sel    = 4'h0;
  logic                ev_dir_en  = 1'b0;
  logic                ev_dir_up  = 1'b0;
  logic                ev_restart = 1'b0;
  logic                dir_dn     = 1'b0;
  tcb_pkg::tcb_wgm_t   wgm        = tcb_pkg::TCB_WG_NORMAL;
  logic                cap_mode   = 1'b0;
  logic                split_en   = 1'b0;
  logic                fine_en    = 1'b0;
  logic                cnt_wr     = 1'b0;
  logic [15:0]         wdata      = 16'h0000;
  logic                per_buf_wr = 1'b0;
  logic [3:0]          cc_en      = 4'hF;
  logic [3:0]          cc_buf_wr  = 4'h0;
  logic [3:0]          cap_ev     = 4'h0;
  logic [3:0]          cc_rd      = 4'h0;
  logic [3:0]          dma_ack_cc = 4'h0;
  logic                ev_go      = 1'b0;
  logic                ack_en     = 1'b1;
  logic                ev_clk, dma_ack_ovf, per_bv_o, bottom_o, max_o, update_o;
  logic                ovf_ev, hovf_ev, err_ev, dma_ovf_req;
  logic [15:0]         cnt_o, per_o, v;
  logic [7:0]          ev_n, n0;
  tcb_pkg::tcb_ch_st_t [3:0] ch_o;
  logic [31:0]         rnd        = 32'hF017EF0B;
  int                  n_errors   = 0;
  int                  tests_run  = 0;
  int                  n_ovf      = 0;
  int                  n_err      = 0;
  int                  n_hovf     = 0;
  int                  n_upd      = 0;
  int                  base;

  always #5 clk = ~clk;

  tcb_timer #(.NUM_CH(4), .FINE_BITS(2)) uut (
    .clk, .rst_b, .ce, .clk_sel, .ev_clk, .ev_dir_en, .ev_dir_up, .ev_restart, .dir_dn, .wgm,
    .cap_mode, .split_en, .fine_en, .cnt_wr, .wdata, .per_buf_wr, .cc_en, .cc_buf_wr, .cap_ev,
    .cc_rd, .dma_ack_ovf, .dma_ack_cc, .cnt_o, .per_o, .per_bv_o, .bottom_o, .max_o, .update_o,
    .ovf_ev, .hovf_ev, .err_ev, .dma_ovf_req, .ch_o
  );

  tcb_evsys_model model (.clk, .rst_b, .ev_go, .ack_en, .dma_ovf_req, .ev_clk, .dma_ack_ovf, .ev_n);

  always @(posedge clk) begin
    if (ovf_ev === 1'b1) n_ovf++;
    if (err_ev === 1'b1) n_err++;
    if (hovf_ev === 1'b1) n_hovf++;
    if (update_o === 1'b1) n_upd++;
  end

  // =====================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_cnt(input logic [15:0] d);
    wdata = d;
    cnt_wr = 1'b1;
    step(1);
    cnt_wr = 1'b0;
  endtask : wr_cnt

  // start and stop latency are equal, so n cycles of clock give n counts
  task automatic run(input int n);
    clk_sel = 4'h1;
    step(n);
    clk_sel = 4'h0;
    step(3);
  endtask : run

  task automatic cap0;
    cap_ev = 4'h1;
    step(1);
    cap_ev = 4'h0;
    step(2);
  endtask : cap0

  task automatic print_verdict;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  // =====================================================================
  // scenarios
  initial begin
    step(4);
    rst_b = 1'b1;
    chk(cnt_o, 16'h0000);
    chk(per_o, 16'hFFFF);
    chk(bottom_o, 1'b1);
    chk({per_bv_o, max_o}, 2'b00);
    clk_sel = 4'h9;
    step(10);
    chk(cnt_o, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : rnd[15:0];
      ev_restart = i[0];
      wr_cnt(v);
      ev_restart = 1'b0;
      chk(cnt_o, v);
      step(1);
      chk(bottom_o, v == 16'h0000);
      chk(max_o, v == 16'hFFFF);
    end
    clk_sel = 4'h8;
    ev_dir_en = 1'b1;
    ev_dir_up = 1'b1;
    ev_restart = 1'b1;
    step(1);
    ev_restart = 1'b0;
    step(2);
    chk(cnt_o, 16'h0000);
    // second pass counts down through bottom, where the period is reloaded
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr_cnt(16'h0003);
      n0 = ev_n;
      v = cnt_o;
      ev_go = 1'b1;
      step(20);
      ev_go = 1'b0;
      step(4);
      chk(cnt_o, (k == 1) ? v - {8'h00, ev_n - n0} : v + {8'h00, ev_n - n0});
      ev_dir_up = 1'b0;
    end
    ev_dir_en = 1'b0;
    clk_sel = 4'h0;
    ack_en = 1'b0;
    wdata = 16'h0009;
    per_buf_wr = 1'b1;
    cc_buf_wr = 4'h2;
    step(1);
    per_buf_wr = 1'b0;
    cc_buf_wr = 4'h0;
    chk({per_bv_o, ch_o[1].bv}, 2'b11);
    chk(per_o, 16'hFFFF);
    base = n_ovf;
    wr_cnt(16'hFFFD);
    run(6);
    chk(cnt_o, 16'h0003);
    chk(per_o, 16'h0009);
    chk({per_bv_o, ch_o[1].bv}, 2'b00);
    chk(ch_o[1].cc, 16'h0009);
    chk(dma_ovf_req, 1'b1);
    run(10);
    chk(cnt_o, 16'h0003);
    chk(16'(n_ovf - base), 16'h0002);
    ack_en = 1'b1;
    step(4);
    chk(dma_ovf_req, 1'b0);
    dir_dn = 1'b1;
    wr_cnt(16'h0002);
    run(5);
    chk(cnt_o, 16'h0007);
    dir_dn = 1'b0;
    cap_mode = 1'b1;
    rnd = lfsr(rnd);
    wr_cnt(rnd[15:0]);
    cap0();
    chk(ch_o[0].cc, rnd[15:0]);
    chk(ch_o[0].full, 1'b1);
    chk(ch_o[0].dma, 1'b1);
    dma_ack_cc = 4'h1;
    step(1);
    dma_ack_cc = 4'h0;
    chk(ch_o[0].dma, 1'b0);
    wr_cnt(rnd[31:16]);
    cap0();
    chk(ch_o[0].buf_v, rnd[31:16]);
    chk(ch_o[0].bv, 1'b1);
    base = n_err;
    cap0();
    chk(16'(n_err - base), 16'h0001);
    cc_rd = 4'h1;
    step(1);
    cc_rd = 4'h0;
    step(2);
    chk(ch_o[0].cc, rnd[31:16]);
    // compare again: channel A value loaded through its buffer, then used as top
    cap_mode = 1'b0;
    wdata = 16'h0004;
    cc_buf_wr = 4'h1;
    step(1);
    cc_buf_wr = 4'h0;
    wr_cnt(16'h0009);
    run(1);
    chk(ch_o[0].cc, 16'h0004);
    wgm = tcb_pkg::TCB_WG_FRQ;
    fine_en = 1'b1;
    wr_cnt(16'h0002);
    base = n_upd;
    run(5);
    chk(cnt_o, 16'h0002);
    chk(16'(n_upd - base), 16'h0001);
    chk(ch_o[1].fine, 3'h1);
    chk(ch_o[0].wave, 1'b1);
    // dual slope turns at the period and gives no update there
    wgm = tcb_pkg::TCB_WG_DS;
    fine_en = 1'b0;
    wr_cnt(16'h0007);
    base = n_upd;
    run(8);
    chk(cnt_o, 16'h0003);
    chk(16'(n_upd - base), 16'h0000);
    // split: both bytes count down, each reloading its own period byte
    wgm = tcb_pkg::TCB_WG_NORMAL;
    split_en = 1'b1;
    ev_restart = 1'b1;
    wr_cnt(16'h0203);
    ev_restart = 1'b0;
    base = n_hovf;
    run(5);
    chk(cnt_o, 16'h0008);
    chk(16'(n_hovf - base), 16'h0003);
    split_en = 1'b0;
    // clock enable low freezes even a count write
    ce = 1'b0;
    clk_sel = 4'h1;
    wr_cnt(16'h0005);
    step(3);
    chk(cnt_o, 16'h0008);
    clk_sel = 4'h0;
    ce = 1'b1;
    step(2);
    // second reset in mid-run
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
    chk(cnt_o, 16'h0000);
    chk(per_o, 16'hFFFF);
    chk({per_bv_o, ch_o[0].bv, ch_o[0].wave}, 3'h0);
    step(3);
    chk(cnt_o, 16'h0000);
    print_verdict();
  end
endmodule : test_timer_counter_base_16bit
